// File: design/csc_pkg.sv
/*
  constants, encodings and timing for the capacitive sense conversion control.
  assumes a single 10 MHz clock domain and plain configuration ports.
*/
package csc_pkg;
  // ==========================================================================
  // widths
  localparam int          RES_W      = 16;
  localparam int          CH_W       = 4;
  localparam int          ACC_W      = 3;
  localparam int          STEP_W     = 5;
  // ==========================================================================
  // conversion length field encodings
  localparam logic [1:0]  LEN_12     = 2'h0;
  localparam logic [1:0]  LEN_13     = 2'h1;
  localparam logic [1:0]  LEN_14     = 2'h2;
  localparam logic [1:0]  LEN_16     = 2'h3;
  localparam logic [1:0]  LEN_RESET  = LEN_13;
  localparam logic [STEP_W-1:0] STEPS_12 = 5'h0C;
  localparam logic [STEP_W-1:0] STEPS_13 = 5'h0D;
  localparam logic [STEP_W-1:0] STEPS_14 = 5'h0E;
  localparam logic [STEP_W-1:0] STEPS_16 = 5'h10;
  localparam logic [RES_W-1:0]  RES_ZERO = 16'h0000;
  localparam logic [RES_W-1:0]  RES_MSB  = 16'h8000;
  localparam logic [CH_W-1:0]   CH_ZERO  = 4'h0;
  localparam logic [CH_W-1:0]   CH_ONE   = 4'h1;
  localparam logic [ACC_W-1:0]  ACC_ZERO = 3'h0;
  localparam logic [ACC_W-1:0]  ACC_ONE  = 3'h1;
  localparam logic [STEP_W-1:0] STEP_ONE = 5'h01;
  // ==========================================================================
  // state machine
  typedef enum logic [1:0] {CSC_IDLE, CSC_CONV, CSC_DONE} csc_state_e;
endpackage

// File: design/csc_sar_step.sv
/*
  one successive-approximation step engine: resolves one bit per clock.
  assumes the analog comparator output is synchronous to CLK.
*/
`timescale 1ns/10ps
module csc_sar_step
  import csc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              start,
  input  wire logic [STEP_W-1:0] steps,
  input  wire logic              cmp_hi,
  output logic [RES_W-1:0]       trial,
  output logic                   done,
  output logic [RES_W-1:0]       result
);
  logic [RES_W-1:0]  probe;
  logic [STEP_W-1:0] left;
  logic              run;
  logic [RES_W-1:0]  next_result;
  logic [RES_W-1:0]  next_probe;

  // ==========================================================================
  // trial code
  // trial leads the registers by one clock, so the registered dac code
  // already shows the bit under test when the comparator is sampled
  always_comb begin
    next_result = result;
    next_probe  = probe;
    if (start) begin
      next_result = RES_ZERO;
      next_probe  = RES_MSB;
    end else if (run) begin
      if (cmp_hi) begin
        next_result = result | probe;
      end
      next_probe = probe >> 1;
    end
    trial = next_result | next_probe;
  end

  // ==========================================================================
  // bit resolution
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result <= RES_ZERO;
      probe  <= RES_ZERO;
      left   <= '0;
      run    <= 1'b0;
      done   <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        result <= RES_ZERO;
        probe  <= RES_MSB;
        left   <= steps;
        run    <= 1'b1;
      end else if (run) begin
        if (cmp_hi) begin
          result <= result | probe;
        end
        probe <= probe >> 1;
        left  <= left - STEP_ONE;
        if (left == STEP_ONE) begin
          run  <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

  // done is registered on the last step, so it is seen one clock after it
  AST_STEP_COUNT: assert property (@(posedge clk) disable iff (!rst_n)
    start && steps == STEPS_12 |-> ##13 done) else $error("12-bit conversion not done on time");
endmodule // csc_sar_step

// File: design/csc_ctrl.sv
/*
  conversion control for the capacitive sense unit: start, continuous and
  auto-scan modes, length selection, accumulation and completion interrupt.
  assumes configuration ports are synchronous and stable during conversions.
*/
`timescale 1ns/10ps
module csc_ctrl
  import csc_pkg::*;
(
  input  wire logic             CLK,
  input  wire logic             RST_N,
  input  wire logic             BUSY_SET,
  input  wire logic             CONT_MODE,
  input  wire logic             SCAN_EN,
  input  wire logic [CH_W-1:0]  CHAN_SEL,
  input  wire logic [CH_W-1:0]  SCAN_END,
  input  wire logic [ACC_W-1:0] ACC_COUNT,
  input  wire logic             LEN_WR,
  input  wire logic [1:0]       LEN_IN,
  input  wire logic             IRQ_EN,
  input  wire logic             DONE_CLR,
  input  wire logic             CMP_HI,
  output logic                  BUSY,
  output logic                  DONE_FLAG,
  output logic                  IRQ,
  output logic [RES_W-1:0]      RESULT,
  output logic [RES_W-1:0]      DAC_TRIAL,
  output logic [CH_W-1:0]       CHAN,
  output logic [1:0]            LEN_FIELD
);
  csc_state_e        state;
  logic [STEP_W-1:0] steps;
  logic              sar_start;
  logic              sar_done;
  logic [RES_W-1:0]  sar_res;
  logic [RES_W-1:0]  sar_trial;
  logic [ACC_W-1:0]  acc_left;
  logic              last_conv;

  // ==========================================================================
  // length field
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      LEN_FIELD <= LEN_RESET;
    end else if (LEN_WR) begin
      LEN_FIELD <= LEN_IN;
    end
  end

  always_comb begin
    case (LEN_FIELD)
      LEN_12:  steps = STEPS_12;
      LEN_13:  steps = STEPS_13;
      LEN_14:  steps = STEPS_14;
      default: steps = STEPS_16;
    endcase
  end

  csc_sar_step u_sar (
    .clk    (CLK),
    .rst_n  (RST_N),
    .start  (sar_start),
    .steps  (steps),
    .cmp_hi (CMP_HI),
    .trial  (sar_trial),
    .done   (sar_done),
    .result (sar_res)
  );

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      DAC_TRIAL <= RES_ZERO;
    end else begin
      DAC_TRIAL <= sar_trial;
    end
  end

  // accumulated sets end on the last conversion
  assign last_conv = (acc_left == ACC_ZERO);

  // ==========================================================================
  // sequencing
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state     <= CSC_IDLE;
      sar_start <= 1'b0;
      acc_left  <= ACC_ZERO;
      CHAN      <= CH_ZERO;
    end else begin
      sar_start <= 1'b0;
      case (state)
        CSC_IDLE: begin
          if (BUSY_SET) begin
            state     <= CSC_CONV;
            sar_start <= 1'b1;
            acc_left  <= ACC_COUNT;
            CHAN      <= CHAN_SEL;
          end
        end
        CSC_CONV: begin
          if (sar_done) begin
            if (!last_conv) begin
              acc_left  <= acc_left - ACC_ONE;
              sar_start <= 1'b1;
            end else begin
              state <= CSC_DONE;
            end
          end
        end
        CSC_DONE: begin
          if (CONT_MODE) begin
            state     <= CSC_CONV;
            sar_start <= 1'b1;
            acc_left  <= ACC_COUNT;
            if (SCAN_EN) begin
              CHAN <= (CHAN == SCAN_END) ? CHAN_SEL : CHAN + CH_ONE;
            end
          end else begin
            state <= CSC_IDLE;
          end
        end
        default: state <= CSC_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // result, busy, flag, interrupt
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RESULT <= RES_ZERO;
    end else if (state == CSC_CONV && sar_done && last_conv) begin
      RESULT <= sar_res;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      BUSY <= 1'b0;
    end else if (BUSY_SET) begin
      BUSY <= 1'b1;
    end else if (state == CSC_CONV && sar_done && last_conv && !CONT_MODE) begin
      BUSY <= 1'b0;
    end else if (state == CSC_DONE && !CONT_MODE) begin
      // continuous mode dropped between sets: stop without leaving busy stuck
      BUSY <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      DONE_FLAG <= 1'b0;
    end else if (state == CSC_CONV && sar_done && last_conv) begin
      DONE_FLAG <= 1'b1;
    end else if (DONE_CLR) begin
      DONE_FLAG <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= DONE_FLAG && IRQ_EN;
    end
  end

  // ==========================================================================
  // checks
  // last conversion of a set completes
  sequence s_final;
    state == CSC_CONV && sar_done && last_conv;
  endsequence

  // a finished set is followed by another in continuous mode
  sequence s_restart;
    state == CSC_DONE && CONT_MODE;
  endsequence

  // a finished set with continuous mode dropped
  sequence s_stop;
    state == CSC_DONE && !CONT_MODE && !BUSY_SET;
  endsequence

  // interrupt request follows the flag only while enabled
  AST_IRQ_GATED: assert property (@(posedge CLK) disable iff (!RST_N)
    IRQ |-> $past(IRQ_EN)) else $error("irq without enable");
  AST_IRQ_FOLLOW: assert property (@(posedge CLK) disable iff (!RST_N)
    DONE_FLAG && IRQ_EN |=> IRQ) else $error("enabled irq missing");

  // length field and unconverted bits
  AST_LEN_RESET: assert property (@(posedge CLK) disable iff (!RST_N)
    $rose(RST_N) |-> LEN_FIELD == LEN_RESET) else $error("length reset wrong");
  AST_ZERO_LOW: assert property (@(posedge CLK) disable iff (!RST_N)
    LEN_FIELD == LEN_12 && $changed(RESULT) |-> RESULT[3:0] == 4'h0) else $error("low bits set");
  AST_ZERO_ALL: assert property (@(posedge CLK) disable iff (!RST_N)
    $changed(RESULT) |-> (RESULT << steps) == RES_ZERO) else $error("stray low bits");

  // one bit per step: each length takes its own number of clocks
  AST_LEN13_TIME: assert property (@(posedge CLK) disable iff (!RST_N)
    sar_start && LEN_FIELD == LEN_13 |-> ##14 sar_done) else $error("13-bit timing wrong");
  AST_LEN14_TIME: assert property (@(posedge CLK) disable iff (!RST_N)
    sar_start && LEN_FIELD == LEN_14 |-> ##15 sar_done) else $error("14-bit timing wrong");
  AST_LEN16_TIME: assert property (@(posedge CLK) disable iff (!RST_N)
    sar_start && LEN_FIELD == LEN_16 |-> ##17 sar_done) else $error("16-bit timing wrong");

  // completion flag only at the end of a set, and sticky until cleared
  AST_ACC_LAST: assert property (@(posedge CLK) disable iff (!RST_N)
    sar_done && !last_conv && !DONE_FLAG && !DONE_CLR |=> !DONE_FLAG) else $error("early done");
  AST_DONE_STICKY: assert property (@(posedge CLK) disable iff (!RST_N)
    DONE_FLAG && !DONE_CLR |=> DONE_FLAG) else $error("done flag dropped");
  AST_SINGLE_END: assert property (@(posedge CLK) disable iff (!RST_N)
    s_final and !CONT_MODE && !BUSY_SET |=> !BUSY && DONE_FLAG) else $error("busy/flag mismatch");

  // starting and busy
  AST_START_GATE: assert property (@(posedge CLK) disable iff (!RST_N)
    state == CSC_IDLE && !BUSY_SET |=> state != CSC_CONV) else $error("start without busy");
  AST_BUSY_HOLD: assert property (@(posedge CLK) disable iff (!RST_N)
    state == CSC_CONV |-> BUSY) else $error("converting while not busy");
  AST_BUSY_RISE: assert property (@(posedge CLK) disable iff (!RST_N)
    BUSY_SET |=> BUSY) else $error("busy not set");

  // continuous mode: restart, channel stepping and stop
  AST_CONT_RESTART: assert property (@(posedge CLK) disable iff (!RST_N)
    s_restart |=> state == CSC_CONV && sar_start) else $error("no restart");
  AST_SCAN_WRAP: assert property (@(posedge CLK) disable iff (!RST_N)
    s_restart and SCAN_EN && CHAN == SCAN_END |=> CHAN == $past(CHAN_SEL))
    else $error("scan did not wrap");
  AST_SCAN_STEP: assert property (@(posedge CLK) disable iff (!RST_N)
    s_restart and SCAN_EN && CHAN != SCAN_END |=> CHAN == $past(CHAN) + CH_ONE)
    else $error("scan did not step");
  AST_FIXED_CHAN: assert property (@(posedge CLK) disable iff (!RST_N)
    s_restart and !SCAN_EN |=> $stable(CHAN)) else $error("fixed channel moved");
  AST_STOP_IDLE: assert property (@(posedge CLK) disable iff (!RST_N)
    s_stop |=> state == CSC_IDLE && !BUSY) else $error("continuous stop left busy");
endmodule // csc_ctrl

// File: tb/csc_electrode.sv
/*
  sense electrode model: answers the comparator for a fixed capacitance code.
  assumes the trial code drives the sense dac directly, with no settling delay.
*/
`timescale 1ns/10ps
module csc_electrode
  import csc_pkg::*;
(
  input  wire logic [RES_W-1:0] trial,
  input  wire logic [RES_W-1:0] cap_code,
  output logic                  cmp_hi
);
  // ==========================================================================
  // comparator
  // keeps the trial bit while the trial code is at or below the electrode
  assign cmp_hi = (trial <= cap_code);
endmodule // csc_electrode

// File: tb/csc_ctrl_bench.sv
/*
  self-checking bench for the conversion control, with random and corner cases.
  assumes csc_ctrl and the csc_electrode model; inputs change on falling edges.
*/
`timescale 1ns/10ps
module csc_ctrl_bench;
  import csc_pkg::*;
  logic             CLK, RST_N, BUSY_SET, CONT_MODE, SCAN_EN, LEN_WR, IRQ_EN;
  logic             DONE_CLR, CMP_HI, BUSY, DONE_FLAG, IRQ;
  logic [CH_W-1:0]  CHAN_SEL, SCAN_END, CHAN;
  logic [ACC_W-1:0] ACC_COUNT;
  logic [1:0]       LEN_IN, LEN_FIELD;
  logic [RES_W-1:0] RESULT, DAC_TRIAL, cap;
  int               errors, total_checks, cyc;
  csc_ctrl csc_ctrl_i (.CLK(CLK), .RST_N(RST_N), .BUSY_SET(BUSY_SET), .CONT_MODE(CONT_MODE),
    .SCAN_EN(SCAN_EN), .CHAN_SEL(CHAN_SEL), .SCAN_END(SCAN_END), .ACC_COUNT(ACC_COUNT),
    .LEN_WR(LEN_WR), .LEN_IN(LEN_IN), .IRQ_EN(IRQ_EN), .DONE_CLR(DONE_CLR), .CMP_HI(CMP_HI),
    .BUSY(BUSY), .DONE_FLAG(DONE_FLAG), .IRQ(IRQ), .RESULT(RESULT), .DAC_TRIAL(DAC_TRIAL),
    .CHAN(CHAN), .LEN_FIELD(LEN_FIELD));
  csc_electrode csc_electrode_i (.trial(DAC_TRIAL), .cap_code(cap), .cmp_hi(CMP_HI));
  // ==========================================================================
  // clock, timeout, checking
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      complete_run();
    end
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d checks %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic int steps(input logic [1:0] len);
    return (len == 2'h0) ? 12 : (len == 2'h1) ? 13 : (len == 2'h2) ? 14 : 16;
  endfunction
  task automatic wait_done(output int n);
    n = 1;
    while (DONE_FLAG !== 1'b1 && n < 400) begin
      @(posedge CLK);
      #1;
      n++;
    end
  endtask
  task automatic clear_done();
    @(negedge CLK);
    DONE_CLR = 1'b1;
    @(negedge CLK);
    DONE_CLR = 1'b0;
  endtask
  // ==========================================================================
  // one single-mode set of conversions
  task automatic conv(input logic [1:0] len, input logic [2:0] acc, input logic ie,
                      input logic [15:0] code);
    int n;
    int st;
    st = steps(len);
    @(negedge CLK);
    LEN_WR = 1'b1;
    LEN_IN = len;
    ACC_COUNT = acc;
    IRQ_EN = ie;
    cap = code;
    @(negedge CLK);
    LEN_WR = 1'b0;
    BUSY_SET = 1'b1;
    check("len_field", 16'(LEN_FIELD), 16'(len));
    @(negedge CLK);
    BUSY_SET = 1'b0;
    @(negedge CLK);
    check("busy_poll", 16'(BUSY), 16'h0001);
    check("dac_first", DAC_TRIAL, RES_MSB);
    wait_done(n);
    check("done_flag", 16'(DONE_FLAG), 16'h0001);
    if (acc == 3'h0) check("conv_cycles", 16'(n), 16'(st + 2));
    else check("acc_cycles", 16'(n), 16'((acc + 1) * (st + 2)));
    check("result", RESULT, code & (16'hFFFF << (16 - st)));
    check("busy_clr", 16'(BUSY), 16'h0000);
    @(posedge CLK);
    #1;
    check("irq", 16'(IRQ), 16'(ie));
    clear_done();
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    int n;
    {RST_N, BUSY_SET, CONT_MODE, SCAN_EN, LEN_WR, IRQ_EN, DONE_CLR} = '0;
    {CHAN_SEL, SCAN_END, ACC_COUNT, LEN_IN, cap} = '0;
    errors = 0;
    total_checks = 0;
    cyc = 0;
    void'($urandom(32'h41E56C07));
    repeat (12) @(negedge CLK);
    RST_N = 1'b1;
    check("len_reset", 16'(LEN_FIELD), 16'h0001);
    conv(LEN_12, 3'h0, 1'b1, 16'hFFFF);
    conv(LEN_16, 3'h0, 1'b0, 16'h0000);
    for (int i = 0; i < 4; i++) conv(2'(i), 3'h0, 1'b1, 16'($urandom));
    for (int i = 0; i < 8; i++) conv(2'($urandom), 3'($urandom), 1'($urandom), 16'($urandom));
    for (int s = 0; s < 2; s++) begin
      @(negedge CLK);
      {CONT_MODE, SCAN_EN, CHAN_SEL, SCAN_END, ACC_COUNT} = {1'b1, 1'(s), 4'h2, 4'h5, 3'h0};
      repeat (30) @(negedge CLK);
      check("cont_idle", 16'(BUSY | DONE_FLAG), 16'h0000);
      BUSY_SET = 1'b1;
      @(negedge CLK);
      BUSY_SET = 1'b0;
      for (int k = 0; k < 2; k++) begin
        wait_done(n);
        check("cont_busy", 16'(BUSY), 16'h0001);
        clear_done();
      end
      check("chan", 16'(CHAN), s ? 16'h0004 : 16'h0002);
      CONT_MODE = 1'b0;
      n = 0;
      while (BUSY !== 1'b0 && n < 200) begin
        @(negedge CLK);
        n++;
      end
      check("cont_stop", 16'(BUSY), 16'h0000);
      clear_done();
    end
    complete_run();
  end
endmodule // csc_ctrl_bench
